// file: shared/i2c_state_regs.svh
// Register offsets, field positions and constants of the bus state tracker.
`ifndef I2C_STATE_REGS_SVH
`define I2C_STATE_REGS_SVH

`define BUS_STATE_OFFSET 12'hf55
`define IRQ_STATUS_OFFSET 12'hf56
`define IRQ_MASK_OFFSET 12'hf57

`define BUS_STATE_RESET 8'h02
`define IRQ_STATUS_RESET 3'h0
`define IRQ_MASK_RESET 3'h0

`define FLD_ACK_VALID 7
`define FLD_ACK 6
`define FLD_ADDR_PHASE 5
`define FLD_DATA_PHASE 4
`define FLD_TEN_BIT 3
`define FLD_RESTART 2
`define FLD_SCL_DRIVE 1
`define FLD_BUSY 0

`define IRQ_STOP_RESTART 0
`define IRQ_ACK_VALID 1
`define IRQ_ADDR_DONE 2
`define IRQ_WIDTH 3

`define TEN_BIT_PREFIX 5'h1e
`define ACK_BIT_INDEX 4'h8

`endif

// file: shared/i2c_state_pkg.sv
// Types shared by the bus state tracker.
package i2c_state_pkg;

  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_ADDR = 2'b01,
    PHASE_ADDR2 = 2'b10,
    PHASE_DATA = 2'b11
  } bus_phase_t;

endpackage : i2c_state_pkg

// file: verilog/i2c_bus_state_tracker.sv
// Bus state tracker of an I2C controller with its state, interrupt status and mask registers.
`timescale 1ns/1ns
`include "i2c_state_regs.svh"

// What this block does
// - While the device sends a byte, the ack valid flag rises once the ack bit of that byte has been sampled.
// - The ack valid flag drops when the next byte starts or when a stop or restart ends the transfer.
// - As master, a start request with an address whose top five bits are the ten-bit prefix sets the ten-bit flag.
// - The ten-bit flag clears once the whole address has been sent on the bus.
// - Every stop or restart event updates the restart indicator, zero for stop and one for restart.
// - The clock drive bit shows the level driven onto the clock line and resets to one.
// - The busy bit is one while a transaction runs on the bus and zero when the bus is idle.

module i2c_bus_state_tracker (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_drive,
  input wire logic master_mode,
  input wire logic sending,
  input wire logic start_request,
  input wire logic [7:0] address_byte,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq
);

  logic scl_meta;
  logic scl_sync;
  logic scl_prev;
  logic sda_meta;
  logic sda_sync;
  logic sda_prev;

  logic scl_rise;
  logic start_seen;
  logic stop_seen;
  logic ack_slot;
  logic byte_first_bit;

  logic [3:0] bit_cnt;
  logic [7:0] shift_byte;
  i2c_state_pkg::bus_phase_t phase;
  i2c_state_pkg::bus_phase_t next_phase;
  logic addr_done;

  logic busy;
  logic ack_valid;
  logic ack_level;
  logic ten_bit;
  logic restart_ind;
  logic clock_drive_level;

  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [`IRQ_WIDTH-1:0] irq_events;
  logic [7:0] bus_state;
  logic status_write;
  logic mask_write;

  // Pins arrive from the bus and are synchronised before anything looks at them.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
    end
  end

  // Start and stop are sda edges while scl stays high on both samples.
  always_comb begin
    scl_rise = scl_sync & ~scl_prev;
    start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
    stop_seen = scl_sync & scl_prev & ~sda_prev & sda_sync;
    ack_slot = busy & scl_rise & (bit_cnt == `ACK_BIT_INDEX);
    byte_first_bit = busy & scl_rise & (bit_cnt == 4'h0);
  end

  // Bit counter and shift register of the byte on the bus.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bit_cnt <= 4'h0;
      shift_byte <= 8'h00;
    end else if (start_seen || stop_seen) begin
      bit_cnt <= 4'h0;
    end else if (busy && scl_rise) begin
      if (bit_cnt == `ACK_BIT_INDEX) begin
        bit_cnt <= 4'h0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
        shift_byte <= {shift_byte[6:0], sda_sync};
      end
    end
  end

  // A start seen while busy is a restart, so busy simply stays set through it.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy <= 1'b0;
    end else if (start_seen) begin
      busy <= 1'b1;
    end else if (stop_seen) begin
      busy <= 1'b0;
    end
  end

  // A first address byte with the ten-bit prefix and a write direction is followed by a second one.
  always_comb begin
    next_phase = phase;
    addr_done = 1'b0;
    if (start_seen) begin
      next_phase = i2c_state_pkg::PHASE_ADDR;
    end else if (stop_seen) begin
      next_phase = i2c_state_pkg::PHASE_IDLE;
    end else if (ack_slot) begin
      case (phase)
        i2c_state_pkg::PHASE_ADDR: begin
          if (shift_byte[7:3] == `TEN_BIT_PREFIX && !shift_byte[0]) begin
            next_phase = i2c_state_pkg::PHASE_ADDR2;
          end else begin
            next_phase = i2c_state_pkg::PHASE_DATA;
            addr_done = 1'b1;
          end
        end
        i2c_state_pkg::PHASE_ADDR2: begin
          next_phase = i2c_state_pkg::PHASE_DATA;
          addr_done = 1'b1;
        end
        default: begin
          next_phase = phase;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase <= i2c_state_pkg::PHASE_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // The ack flag is cleared at the first bit of the next byte, which never meets an ack slot.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_valid <= 1'b0;
    end else if (ack_slot && sending) begin
      ack_valid <= 1'b1;
    end else if (byte_first_bit || start_seen || stop_seen) begin
      ack_valid <= 1'b0;
    end
  end

  // The ack bit keeps the raw line level, so a zero means the byte was acknowledged.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_level <= 1'b0;
    end else if (ack_slot) begin
      ack_level <= sda_sync;
    end else if (start_seen && !busy) begin
      ack_level <= 1'b0;
    end
  end

  // A restart within one transaction keeps the flag, since the address still has to go out.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ten_bit <= 1'b0;
    end else if (master_mode && start_request && address_byte[7:3] == `TEN_BIT_PREFIX) begin
      ten_bit <= 1'b1;
    end else if (addr_done) begin
      ten_bit <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      restart_ind <= 1'b0;
    end else if (stop_seen) begin
      restart_ind <= 1'b0;
    end else if (start_seen && busy) begin
      restart_ind <= 1'b1;
    end
  end

  // The drive level comes from logic on this clock, so it needs no synchroniser.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clock_drive_level <= 1'b1;
    end else begin
      clock_drive_level <= scl_drive;
    end
  end

  always_comb begin
    bus_state = `BUS_STATE_RESET;
    bus_state[`FLD_ACK_VALID] = ack_valid;
    bus_state[`FLD_ACK] = ack_level;
    bus_state[`FLD_ADDR_PHASE] = (phase == i2c_state_pkg::PHASE_ADDR) || (phase == i2c_state_pkg::PHASE_ADDR2);
    bus_state[`FLD_DATA_PHASE] = (phase == i2c_state_pkg::PHASE_DATA);
    bus_state[`FLD_TEN_BIT] = ten_bit;
    bus_state[`FLD_RESTART] = restart_ind;
    bus_state[`FLD_SCL_DRIVE] = clock_drive_level;
    bus_state[`FLD_BUSY] = busy;
  end

  // Events that feed the sticky interrupt status.
  always_comb begin
    irq_events = {`IRQ_WIDTH{1'b0}};
    irq_events[`IRQ_STOP_RESTART] = stop_seen || (start_seen && busy);
    irq_events[`IRQ_ACK_VALID] = ack_slot && sending;
    irq_events[`IRQ_ADDR_DONE] = addr_done;
  end

  // Register writes are decoded once, so that status and mask see the same address compare.
  always_comb begin
    status_write = reg_wr && (reg_addr == `IRQ_STATUS_OFFSET);
    mask_write = reg_wr && (reg_addr == `IRQ_MASK_OFFSET);
  end

  // An event in the same cycle as a write-one-to-clear keeps its bit set.
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_status
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          irq_status[gi] <= 1'b0;
        end else if (irq_events[gi]) begin
          irq_status[gi] <= 1'b1;
        end else if (status_write && reg_wdata[gi]) begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_mask <= `IRQ_MASK_RESET;
    end else if (mask_write) begin
      irq_mask <= reg_wdata[`IRQ_WIDTH-1:0];
    end
  end

  // The output lags the status by one cycle so that it comes straight from a flip-flop.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Unmapped addresses read as zero; the state register ignores writes.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `BUS_STATE_OFFSET: begin
          reg_rdata <= bus_state;
        end
        `IRQ_STATUS_OFFSET: begin
          reg_rdata <= {5'h00, irq_status};
        end
        `IRQ_MASK_OFFSET: begin
          reg_rdata <= {5'h00, irq_mask};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : i2c_bus_state_tracker

// file: dv/i2c_bus_peer.sv
// Bus peer that drives both lines.
`timescale 1ns/1ns
module i2c_bus_peer (
  output logic scl,
  output logic sda
);
  // Both lines stand high between frames, as the pull-ups leave them.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start_cond();
    #3;
    sda = 1'b0;
    #80;
    scl = 1'b0;
    #40;
  endtask : start_cond
  task automatic restart_cond();
    sda = 1'b1;
    #40;
    scl = 1'b1;
    #40;
    start_cond();
  endtask : restart_cond
  task automatic stop_cond();
    sda = 1'b0;
    #40;
    scl = 1'b1;
    #40;
    sda = 1'b1;
    #80;
  endtask : stop_cond
  task automatic put_byte(input logic [7:0] b, input logic ack);
    logic [8:0] v;
    v = {b, ack};
    for (int i = 8; i >= 0; i--) begin
      sda = v[i];
      #40;
      scl = 1'b1;
      #80;
      scl = 1'b0;
      #40;
    end
  endtask : put_byte
endmodule : i2c_bus_peer

// file: dv/i2c_bus_state_tracker_assertions.sv
// Port assertions of the bus state tracker.
`timescale 1ns/1ns
module i2c_bus_state_tracker_checker (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_drive,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq
);
  logic st_rd;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  always_ff @(posedge ref_clk) st_rd <= reg_rd && reg_addr == 12'hf55;
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  AST_UNMAPPED: assert property (reg_rd && !(reg_addr inside {[12'hf55:12'hf57]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_STATUS_TOP: assert property (reg_rd && reg_addr inside {12'hf56, 12'hf57} |=> reg_rdata[7:3] == 5'h00)
    else $error("unused bits set");
  AST_SCL_LEVEL: assert property (st_rd && $past(scl_drive) == $past(scl_drive, 2)
    |-> reg_rdata[1] == $past(scl_drive)) else $error("clock drive bit wrong");
  AST_PHASE_EXCL: assert property (st_rd |-> !(reg_rdata[5] && reg_rdata[4]))
    else $error("both phases set");
  AST_IDLE_CLEAN: assert property (st_rd && !reg_rdata[0] |-> (reg_rdata & 8'hb4) == 8'h00)
    else $error("idle bus flags set");
  AST_MASK_OFF: assert property (reg_wr && reg_addr == 12'hf57 && reg_wdata[2:0] == 3'h0 |=> ##1 !irq)
    else $error("irq with empty mask");
  AST_IRQ_RESET: assert property ($fell(srst) |-> !irq)
    else $error("irq after reset");
  COV_ACK_RESULT_VALID: cover property (st_rd && reg_rdata[7]);
  COV_RESTART: cover property (st_rd && reg_rdata[2]);
  COV_IRQ: cover property ($rose(irq));
endmodule : i2c_bus_state_tracker_checker
bind i2c_bus_state_tracker i2c_bus_state_tracker_checker chk_i (.ref_clk(ref_clk), .srst(srst),
  .scl_drive(scl_drive), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// file: dv/i2c_bus_state_tracker_tb_top.sv
// Self-checking bench of the bus state tracker.
`timescale 1ns/1ns
module i2c_bus_state_tracker_tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic scl_in, sda_in, reg_wr, reg_rd, start_request, irq, scl_drive, master_mode, sending;
  logic [7:0] address_byte, reg_wdata, reg_rdata, b;
  logic [11:0] reg_addr;
  logic [7:0] st = 8'h02;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 32'h6004a669;
  always #4 ref_clk = ~ref_clk;
  i2c_bus_peer peer (.scl(scl_in), .sda(sda_in));
  i2c_bus_state_tracker dut (.ref_clk, .srst, .scl_in, .sda_in, .scl_drive, .master_mode, .sending,
    .start_request, .address_byte, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(e & m, reg_rdata & m);
  endtask : rd
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({7'h00, e}, {7'h00, irq});
  endtask : irq_chk
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    {reg_wr, reg_rd, start_request, master_mode, sending, scl_drive} = 6'h01;
    {address_byte, reg_wdata, reg_addr} = 28'h0;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    rd(12'hf55, st, 8'hff);
    rd(12'hf56, 8'h00, 8'hff);
    rd(12'hf57, 8'h00, 8'hff);
    rd(12'h3a0, 8'h00, 8'hff);
    wr(12'hf55, 8'hfd);
    b = $random(seed);
    scl_drive <= b[0];
    st[1] = b[0];
    rd(12'hf55, st, 8'hff);
    wr(12'hf57, 8'h01);
    {master_mode, sending, address_byte, start_request} <= {2'b11, 8'hf0, 1'b1};
    @(posedge ref_clk);
    start_request <= 1'b0;
    st[3] = 1'b1;
    rd(12'hf55, st, 8'hff);
    peer.start_cond();
    st = st & 8'hbf | 8'h21;
    rd(12'hf55, st, 8'hff);
    peer.put_byte(8'hf0, 1'b0);
    st[7] = 1'b1;
    rd(12'hf55, st, 8'hff);
    b = $random(seed);
    peer.put_byte(b, 1'b0);
    st = st & 8'hd7 | 8'h10;
    rd(12'hf55, st, 8'hff);
    b = $random(seed);
    peer.put_byte(b, b[7]);
    st[6] = b[7];
    rd(12'hf55, st, 8'hff);
    peer.restart_cond();
    st = st & 8'h4f | 8'h24;
    rd(12'hf55, st, 8'hff);
    rd(12'hf56, 8'h07, 8'hff);
    irq_chk(1'b1);
    wr(12'hf56, 8'h07);
    irq_chk(1'b0);
    peer.stop_cond();
    st = st & 8'h42;
    rd(12'hf55, st, 8'hff);
    irq_chk(1'b1);
    wr(12'hf57, 8'h00);
    irq_chk(1'b0);
    {master_mode, sending, start_request} <= 3'b001;
    @(posedge ref_clk);
    start_request <= 1'b0;
    rd(12'hf55, st, 8'hff);
    peer.start_cond();
    st = st & 8'hbf | 8'h21;
    rd(12'hf55, st, 8'hff);
    b = $random(seed);
    peer.put_byte(b & 8'h7f, 1'b1);
    st = st & 8'h0f | 8'h50;
    rd(12'hf55, st, 8'hff);
    peer.stop_cond();
    st = st & 8'h42;
    rd(12'hf55, st, 8'hff);
    rd(12'hf56, 8'h05, 8'hff);
    irq_chk(1'b0);
    summarize();
  end
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule : i2c_bus_state_tracker_tb_top
